// ---- design/iroi_pkg.sv ----
// Contract
// - Window width and height are accepted only as multiples of 32 pixels.
// - Width below 640 or height below 32 pixels is refused.
// - The window is centred vertically on the sensor array.
// - Any size change recomputes both offsets to keep the window centred.
// - Vertical offset is read-only, origin to window top, in pixels.
// - Effective array width and height are read-only values in pixels.
// - Largest allowed width and height follow the present configuration; here both are fixed at the full array.
// - Only pixels inside the window leave the block, unaltered; the code keeps the pixel data but re-marks sof and sol for the cropped frame.
// - Horizontal offset is software-writable, origin to window, in pixels.
// - Size changes are taken only in single-channel link mode.
package iroi_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int          DIM_W       = 13;
  localparam int          PIX_W       = 10;
  localparam int          FIFO_DEPTH  = 16;
  localparam logic [12:0] ARRAY_COLS  = 13'h1400;
  localparam logic [12:0] ARRAY_ROWS  = 13'h1000;
  localparam logic [12:0] ALIGN_MASK  = 13'h001F;
  localparam logic [12:0] MIN_COLS    = 13'h0280;
  localparam logic [12:0] MIN_ROWS    = 13'h0020;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_COLS     = 8'h00;
  localparam logic [7:0] REG_ROWS     = 8'h04;
  localparam logic [7:0] REG_LEFT     = 8'h08;
  localparam logic [7:0] REG_TOP      = 8'h0C;
  localparam logic [7:0] REG_ARR_COLS = 8'h10;
  localparam logic [7:0] REG_ARR_ROWS = 8'h14;
  localparam logic [7:0] REG_MAX_COLS = 8'h18;
  localparam logic [7:0] REG_MAX_ROWS = 8'h1C;
  localparam logic [7:0] REG_CTRL     = 8'h20;
  localparam logic [7:0] REG_LINE     = 8'h24;
  localparam logic [7:0] REG_STAT     = 8'h28;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_DUAL_BIT = 0;
  localparam int          CTRL_P10_BIT  = 1;
  localparam int          STAT_REJ_BIT  = 0;
  localparam logic [12:0] RST_LEFT      = 13'h0000;
  localparam logic [12:0] RST_COLS      = 13'h1400;
  localparam logic [12:0] RST_ROWS      = 13'h1000;
  localparam logic [13:0] RST_LINE      = 14'h1400;

  typedef struct packed {
    logic             sof;
    logic             sol;
    logic [PIX_W-1:0] data;
  } iroi_pix_t;

endpackage : iroi_pkg

// ---- design/iroi_fifo.sv ----
module iroi_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } iroi_fifo_st_t;

  iroi_fifo_st_t   st_ff;
  iroi_fifo_st_t   nxt_st;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic            push;
  logic            pop;

  assign in_ready_o  = (st_ff.cnt != DEPTH[AW:0]);
  assign out_valid_o = (st_ff.cnt != '0);
  assign out_data_o  = mem_ff[st_ff.rd];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb
  begin
    nxt_st = st_ff;
    if (push)
    begin
      nxt_st.wr = st_ff.wr + 1'b1;
    end
    if (pop)
    begin
      nxt_st.rd = st_ff.rd + 1'b1;
    end
    if (push && !pop)
    begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Storage needs no reset; occupancy guards reads
  always_ff @(posedge ref_clk_i)
  begin
    if (push)
    begin
      mem_ff[st_ff.wr] <= in_data_i;
    end
  end
endmodule // iroi_fifo

// ---- design/iroi_top.sv ----
// The placing of the registers and the APB register port are this design's own decisions.
module iroi_top (
  input  wire logic               ref_clk_i,
  input  wire logic               rst_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [7:0]         paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic                    pready_o,
  output logic      [31:0]        prdata_o,
  output logic                    pslverr_o,
  input  wire logic               pix_valid_i,
  output logic                    pix_ready_o,
  input  wire iroi_pkg::iroi_pix_t pix_i,
  output logic                    out_valid_o,
  input  wire logic               out_ready_i,
  output iroi_pkg::iroi_pix_t     out_o,
  output logic      [13:0]        grabber_line_length_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [12:0] cols;
    logic [12:0] rows;
    logic [12:0] left;
    logic        dual;
    logic        p10;
    logic        rej;
    logic [12:0] x;
    logic [12:0] y;
    logic [31:0] rdata;
    logic        err;
    logic [13:0] line;
  } iroi_st_t;

  // Reset selects the full array, which is centred by itself
  localparam iroi_st_t RST_ST = '{
    cols:  iroi_pkg::RST_COLS,
    rows:  iroi_pkg::RST_ROWS,
    left:  iroi_pkg::RST_LEFT,
    dual:  1'b0,
    p10:   1'b0,
    rej:   1'b0,
    x:     13'h0000,
    y:     13'h0000,
    rdata: 32'h0000_0000,
    err:   1'b0,
    line:  iroi_pkg::RST_LINE
  };

  iroi_st_t            st_ff;
  iroi_st_t            nxt_st;
  logic                setup;
  logic                acc;
  logic                wr;
  logic [31:0]         rd_word;
  logic                addr_ok;
  logic                wr_bad;
  logic                rej_clr;
  logic                hi_zero;
  logic [12:0]         wval;
  logic                cols_ok;
  logic                rows_ok;
  logic                left_ok;
  logic [12:0]         max_cols;
  logic [12:0]         max_rows;
  logic [12:0]         max_left;
  logic [12:0]         top;
  logic [12:0]         win_right;
  logic [12:0]         win_bot;
  logic [12:0]         cur_x;
  logic [12:0]         cur_y;
  logic                take;
  logic                in_win;
  logic                f_ready;
  logic                f_valid;
  iroi_pkg::iroi_pix_t w_pix;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  // Zero wait states: the access phase lasts one cycle
  assign setup     = psel_i & ~penable_i;
  assign acc       = psel_i & penable_i;
  assign wr        = acc & pwrite_i;
  assign pready_o  = acc;
  assign prdata_o  = st_ff.rdata;
  assign pslverr_o = st_ff.err;

  // ----------------------------------------------------------------
  // Limits and geometry
  // ----------------------------------------------------------------
  // No binning here, so the ceilings are the full array
  // ceiling values
  assign max_cols  = iroi_pkg::ARRAY_COLS;
  assign max_rows  = iroi_pkg::ARRAY_ROWS;

  assign top       = (iroi_pkg::ARRAY_ROWS - st_ff.rows) >> 1;
  assign max_left  = iroi_pkg::ARRAY_COLS - st_ff.cols;
  assign win_right = st_ff.left + st_ff.cols;
  assign win_bot   = top + st_ff.rows;

  // ----------------------------------------------------------------
  // Write value checks
  // ----------------------------------------------------------------
  assign wval    = pwdata_i[12:0];
  assign hi_zero = (pwdata_i[31:13] == 19'h0_0000);

  assign cols_ok = hi_zero
                 & ((wval & iroi_pkg::ALIGN_MASK) == 13'h0000)
                 & (wval >= iroi_pkg::MIN_COLS)
                 & (wval <= max_cols)
                 & ~st_ff.dual;

  assign rows_ok = hi_zero
                 & ((wval & iroi_pkg::ALIGN_MASK) == 13'h0000)
                 & (wval >= iroi_pkg::MIN_ROWS)
                 & (wval <= max_rows)
                 & ~st_ff.dual;

  assign left_ok = hi_zero
                 & (wval <= max_left);

  assign rej_clr = wr
                 & (paddr_i == iroi_pkg::REG_STAT)
                 & pwdata_i[iroi_pkg::STAT_REJ_BIT];

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb
  begin
    addr_ok = 1'b1;
    wr_bad  = 1'b0;
    rd_word = 32'h0000_0000;
    case (paddr_i)
      iroi_pkg::REG_COLS:
      begin
        rd_word = 32'(st_ff.cols);
        wr_bad  = ~cols_ok;
      end
      iroi_pkg::REG_ROWS:
      begin
        rd_word = 32'(st_ff.rows);
        wr_bad  = ~rows_ok;
      end
      iroi_pkg::REG_LEFT:
      begin
        rd_word = 32'(st_ff.left);
        wr_bad  = ~left_ok;
      end
      iroi_pkg::REG_TOP:
      begin
        rd_word = 32'(top);
        wr_bad  = 1'b1;
      end
      iroi_pkg::REG_ARR_COLS:
      begin
        rd_word = 32'(iroi_pkg::ARRAY_COLS);
        wr_bad  = 1'b1;
      end
      iroi_pkg::REG_ARR_ROWS:
      begin
        rd_word = 32'(iroi_pkg::ARRAY_ROWS);
        wr_bad  = 1'b1;
      end
      iroi_pkg::REG_MAX_COLS:
      begin
        rd_word = 32'(max_cols);
        wr_bad  = 1'b1;
      end
      iroi_pkg::REG_MAX_ROWS:
      begin
        rd_word = 32'(max_rows);
        wr_bad  = 1'b1;
      end
      iroi_pkg::REG_CTRL:
      begin
        rd_word[iroi_pkg::CTRL_DUAL_BIT] = st_ff.dual;
        rd_word[iroi_pkg::CTRL_P10_BIT]  = st_ff.p10;
      end
      iroi_pkg::REG_LINE:
      begin
        rd_word = 32'(st_ff.line);
        wr_bad  = 1'b1;
      end
      iroi_pkg::REG_STAT:
      begin
        rd_word[iroi_pkg::STAT_REJ_BIT] = st_ff.rej;
      end
      default:
      begin
        addr_ok = 1'b0;
        wr_bad  = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    // Read data and error are caught in the setup phase
    if (setup)
    begin
      nxt_st.rdata = pwrite_i ? st_ff.rdata : rd_word;
      nxt_st.err   = ~addr_ok | (pwrite_i & wr_bad);
    end
    else
    begin
      nxt_st.err = 1'b0;
    end

    // Writes land on the access edge only
    if (wr && !wr_bad)
    begin
      case (paddr_i)
        iroi_pkg::REG_COLS:
        begin
          nxt_st.cols = wval;
          nxt_st.left = (iroi_pkg::ARRAY_COLS - wval) >> 1;
        end
        iroi_pkg::REG_ROWS:
        begin
          nxt_st.rows = wval;
          nxt_st.left = (iroi_pkg::ARRAY_COLS - st_ff.cols) >> 1;
        end
        iroi_pkg::REG_LEFT:
        begin
          nxt_st.left = wval;
        end
        iroi_pkg::REG_CTRL:
        begin
          nxt_st.dual = pwdata_i[iroi_pkg::CTRL_DUAL_BIT];
          nxt_st.p10  = pwdata_i[iroi_pkg::CTRL_P10_BIT];
        end
        default:
        begin
        end
      endcase
    end

    // Set wins over a clear in the same cycle
    if (rej_clr)
    begin
      nxt_st.rej = 1'b0;
    end
    if (wr && wr_bad)
    begin
      nxt_st.rej = 1'b1;
    end

    // Taken from the next values so it lands with the write
    if (nxt_st.p10 && !nxt_st.dual)
    begin
      nxt_st.line = {nxt_st.cols, 1'b0};
    end
    else
    begin
      nxt_st.line = {1'b0, nxt_st.cols};
    end

    // Position follows the accepted stream
    if (take)
    begin
      nxt_st.x = cur_x + 13'h0001;
      nxt_st.y = cur_y;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_ff <= RST_ST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Window crop
  // ----------------------------------------------------------------
  // Resizing mid-frame tears that frame; software waits for a gap
  assign take  = pix_valid_i & f_ready;
  // Line starts reset the column and step the row; frame starts reset both
  assign cur_x = (pix_i.sof | pix_i.sol) ? 13'h0000
               : st_ff.x;
  assign cur_y = pix_i.sof ? 13'h0000
               : (pix_i.sol ? st_ff.y + 13'h0001
                            : st_ff.y);

  assign in_win = (cur_x >= st_ff.left)
                & (cur_x < win_right)
                & (cur_y >= top)
                & (cur_y < win_bot);

  // Start flags re-marked for the cropped frame
  assign w_pix.sof  = (cur_x == st_ff.left)
                    & (cur_y == top);
  assign w_pix.sol  = (cur_x == st_ff.left);
  assign w_pix.data = pix_i.data;
  assign f_valid    = pix_valid_i & in_win;
  // Pixels outside the window are taken and dropped
  assign pix_ready_o           = f_ready;
  assign grabber_line_length_o = st_ff.line;

  // ----------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------
  // Sixteen words absorb a stalled grabber
  iroi_fifo #(
    .WIDTH ($bits(iroi_pkg::iroi_pix_t)),
    .DEPTH (iroi_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (f_valid),
    .in_ready_o  (f_ready),
    .in_data_i   (w_pix),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i),
    .out_data_o  (out_o)
  );

endmodule // iroi_top

// ---- sim/iroi_chk_sva.sv ----
module iroi_chk (
  input wire logic                ref_clk_i,
  input wire logic                rst_i,
  input wire logic                psel_i,
  input wire logic                penable_i,
  input wire logic                pwrite_i,
  input wire logic [7:0]          paddr_i,
  input wire logic                pready_o,
  input wire logic [31:0]         prdata_o,
  input wire logic                out_valid_o,
  input wire logic                out_ready_i,
  input wire iroi_pkg::iroi_pix_t out_o,
  input wire logic [13:0]         grabber_line_length_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire rd = psel_i && penable_i && pready_o && !pwrite_i;
  property p_acol; rd && paddr_i == iroi_pkg::REG_ARR_COLS
    |-> prdata_o == 32'(iroi_pkg::ARRAY_COLS); endproperty
  property p_arow; rd && paddr_i == iroi_pkg::REG_ARR_ROWS
    |-> prdata_o == 32'(iroi_pkg::ARRAY_ROWS); endproperty
  property p_col; rd && paddr_i == iroi_pkg::REG_COLS
    |-> prdata_o[4:0] == 5'h00 && prdata_o >= 32'h280; endproperty
  property p_row; rd && paddr_i == iroi_pkg::REG_ROWS
    |-> prdata_o[4:0] == 5'h00 && prdata_o >= 32'h20; endproperty
  property p_hold; out_valid_o && !out_ready_i
    |=> out_valid_o && $stable(out_o); endproperty
  property p_mcol; rd && paddr_i == iroi_pkg::REG_MAX_COLS
    |-> prdata_o == 32'(iroi_pkg::ARRAY_COLS); endproperty
  property p_line; grabber_line_length_o[4:0] == 5'h00
    && grabber_line_length_o >= 14'h0280; endproperty
  a_acol: assert property (p_acol) else $error("array cols");
  a_arow: assert property (p_arow) else $error("array rows");
  a_col: assert property (p_col) else $error("bad width");
  a_row: assert property (p_row) else $error("bad height");
  a_hold: assert property (p_hold) else $error("pixel lost");
  a_mcol: assert property (p_mcol) else $error("max cols");
  a_line: assert property (p_line) else $error("line length");
  c_rd: cover property (rd);
  c_wr: cover property (psel_i && penable_i && pready_o && pwrite_i);
  c_out: cover property (out_valid_o && out_ready_i);
endmodule // iroi_chk
bind iroi_top iroi_chk u_chk (.*);

// ---- sim/iroi_grab.sv ----
module iroi_grab (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  output logic      ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_ff;
  // Slow sink, ready one cycle in four
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i) cnt_ff <= 2'h0;
    else cnt_ff <= cnt_ff + 2'h1;
  assign ready_o = cnt_ff == 2'h3;
endmodule // iroi_grab

// ---- sim/iroi_top_tb.sv ----
module iroi_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic pix_valid_i = 0, out_ready_i, out_valid_o, pready_o;
  logic pslverr_o, pix_ready_o;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [13:0] grabber_line_length_o;
  iroi_pkg::iroi_pix_t pix_i = '0, out_o;
  int error_cnt = 0, n_tests = 0, n_out = 0;
  logic [11:0] got_pix [4];
  always #2 ref_clk_i = ~ref_clk_i;
  iroi_top uut (.*);
  iroi_grab u_grab (.ref_clk_i, .rst_i, .ready_o(out_ready_i));
  always @(posedge ref_clk_i)
    if (out_valid_o === 1'b1 && out_ready_i === 1'b1)
    begin
      if (n_out < 4) got_pix[n_out] = out_o;
      n_out++;
    end
  task automatic px(input logic f, input logic l, input logic [9:0] d);
    pix_valid_i <= 1'b1;
    pix_i <= '{sof: f, sol: l, data: d};
    do @(posedge ref_clk_i); while (pix_ready_o !== 1'b1);
  endtask
  task automatic ap(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    ap(0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    finish_test;
  end
  initial
  begin
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 0;
    rc(iroi_pkg::REG_ARR_COLS, 32'(iroi_pkg::ARRAY_COLS));
    rc(iroi_pkg::REG_ARR_ROWS, 32'(iroi_pkg::ARRAY_ROWS));
    $display("test array done");
    ap(1, iroi_pkg::REG_COLS, 32'h280);
    ap(1, iroi_pkg::REG_ROWS, 32'h20);
    rc(iroi_pkg::REG_TOP, 32'((iroi_pkg::ARRAY_ROWS - 13'h20) >> 1));
    rc(iroi_pkg::REG_LEFT, 32'((iroi_pkg::ARRAY_COLS - 13'h280) >> 1));
    $display("test centre done");
    ap(1, iroi_pkg::REG_COLS, 32'h290);
    rc(iroi_pkg::REG_COLS, 32'h280);
    ap(1, iroi_pkg::REG_COLS, 32'h260);
    rc(iroi_pkg::REG_COLS, 32'h280);
    ap(1, iroi_pkg::REG_CTRL, 32'h1);
    ap(1, iroi_pkg::REG_COLS, 32'h400);
    rc(iroi_pkg::REG_COLS, 32'h280);
    ap(1, iroi_pkg::REG_CTRL, 32'h2);
    @(posedge ref_clk_i);
    chk(32'(grabber_line_length_o), 32'h500);
    $display("test refuse done");
    ap(1, iroi_pkg::REG_LEFT, 32'h0);
    rc(iroi_pkg::REG_LEFT, 32'h0);
    rc(iroi_pkg::REG_MAX_COLS, 32'(iroi_pkg::ARRAY_COLS));
    rc(iroi_pkg::REG_STAT, 32'h1);
    ap(1, iroi_pkg::REG_STAT, 32'h1);
    rc(iroi_pkg::REG_STAT, 32'h0);
    // Window top is line 2032: two pixels per line reach it
    for (int ln = 0; ln < 2034; ln++)
    begin
      px(ln == 0, 1'b1, 10'(2 * ln));
      px(1'b0, 1'b0, 10'(2 * ln + 1));
    end
    pix_valid_i <= 1'b0;
    repeat (40) @(posedge ref_clk_i);
    chk(32'(n_out), 32'h4);
    chk(32'(got_pix[0]), 32'hFE0);
    chk(32'(got_pix[1]), 32'h3E1);
    chk(32'(got_pix[2]), 32'h7E2);
    chk(32'(got_pix[3]), 32'h3E3);
    $display("test window done");
    finish_test;
  end
endmodule // iroi_top_tb
